// ===== include/sdram_cmd_regs.svh
`ifndef SDRAM_CMD_REGS_SVH
`define SDRAM_CMD_REGS_SVH
// ----------------------------------------
// register offsets
// ----------------------------------------
`define REG_CTRL   8'h00
`define REG_CMD    8'h04
`define REG_ADDR   8'h08
`define REG_WDATA  8'h0c
`define REG_BE     8'h10
`define REG_STAT   8'h14
`define REG_RDATA  8'h18
// ----------------------------------------
// fields
// ----------------------------------------
`define CTRL_RL    1:0
`define CTRL_WL    3:2
`define CMD_CODE   3:0
`define CMD_SRC    4
`define CMD_DST    5
`define ADDR_ROW   12:0
`define ADDR_COL   22:13
`define ADDR_BANK  24:23
`define BE_FIELD   3:0
`define AP_BIT     10
// ----------------------------------------
// timing and reset values
// ----------------------------------------
`define CAS_LAT    4'h3
`define CNT_ONE    4'h1
`define RST_LAT    2'h0
`define RST_WORD   32'h0000_0000
`endif

// ===== include/sdram_cmd_pkg.sv
package sdram_cmd_pkg;
    localparam int ADDR_W = 13;
    localparam int COL_W  = 10;
    localparam int BANK_W = 2;
    localparam int DATA_W = 32;
    localparam int BE_W   = 4;
    localparam int NBANK  = 4;

    typedef enum logic [3:0] {
        CMD_NOP       = 4'h0,
        CMD_ACTIVATE  = 4'h1,
        CMD_READ      = 4'h2,
        CMD_WRITE     = 4'h3,
        CMD_PRE_ALL   = 4'h4,
        CMD_PRE_BANK  = 4'h5,
        CMD_REFRESH   = 4'h6,
        CMD_MODE_SET  = 4'h7,
        CMD_SREF_IN   = 4'h8,
        CMD_SREF_OUT  = 4'h9
    } cmd_e;

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_PRE  = 4'b0010,
        ST_ACT  = 4'b0100,
        ST_RUN  = 4'b1000
    } link_state_e;

    typedef struct packed {
        logic              cs_n;
        logic              ras_n;
        logic              cas_n;
        logic              we_n;
        logic              cke;
        logic              strobe;
        logic [ADDR_W-1:0] addr;
        logic [BANK_W-1:0] bank;
        logic [BE_W-1:0]   be_n;
        logic [DATA_W-1:0] data;
        logic              oe;
    } pins_s;

    typedef struct packed {
        cmd_e              cmd;
        logic              src;
        logic              dst;
        logic [1:0]        rl;
        logic [1:0]        wl;
        logic [ADDR_W-1:0] row;
        logic [COL_W-1:0]  col;
        logic [BANK_W-1:0] bank;
        logic [DATA_W-1:0] wdata;
        logic [BE_W-1:0]   be;
    } req_s;
endpackage

// ===== rtl/sdram_command_port.sv
// Notes on behaviour
// - during sdram access the shared strobe pins act as column, write and row strobes.
// - all pins launch from, and read data is sampled at, the memory clock rising edge.
// - read data is taken three memory clocks after the read command.
// - write data and byte enables go out with the column address and write strobe.
// - a row activate opens the row before any read or write to it.
// - a precharge-all command closes every open row.
// - a bank precharge closes only the addressed bank.
// - the clock-enable pin is driven only on the wide interface.
// - the direct strobe fires only when the matching direct flag is set.
// - a direct read does not latch the returned data.
// - a two-bit field delays the direct strobe 0 to 3 cycles after read data.
// - a direct write leaves the data bus undriven.
// - a two-bit field delays the direct strobe 0 to 3 cycles after write data.
// - an auto-refresh command can be issued on both interfaces.
// - a mode-register-set command can be issued on both interfaces.
// - self-refresh entry and exit via clock enable exist only on the wide interface.
//
// Chosen here: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
`include "sdram_cmd_regs.svh"
`default_nettype none

module sdram_command_port #(
    parameter bit         WIDE = 1'b1,
    parameter logic [3:0] GAP  = 4'h2
) (
    input  wire logic                               i_core_clk,
    input  wire logic                               i_rstn,
    input  wire logic [7:0]                         i_addr,
    input  wire logic [31:0]                        i_wdata,
    input  wire logic                               i_wr,
    input  wire logic                               i_rd,
    output logic      [31:0]                        o_rdata,
    input  wire logic                               i_mem_clk,
    output logic                                    o_memory_clock_out,
    output logic                                    o_chip_select_n,
    output logic                                    o_row_strobe_n,
    output logic                                    o_column_strobe_n,
    output logic                                    o_mem_write_strobe_n,
    output logic                                    o_sdram_clock_enable_wide,
    output logic                                    o_direct_transfer_strobe,
    output logic      [sdram_cmd_pkg::ADDR_W-1:0]   o_external_address_bus,
    output logic      [sdram_cmd_pkg::BANK_W-1:0]   o_bank,
    output logic      [sdram_cmd_pkg::BE_W-1:0]     o_byte_enable_n,
    output logic      [sdram_cmd_pkg::DATA_W-1:0]   o_external_data_bus,
    output logic                                    o_external_data_bus_oe,
    input  wire logic [sdram_cmd_pkg::DATA_W-1:0]   i_external_data_bus
);

    // ----------------------------------------
    // state types
    // ----------------------------------------
    typedef struct packed {
        logic [1:0]                   rl;
        logic [1:0]                   wl;
        logic [sdram_cmd_pkg::ADDR_W-1:0] row;
        logic [sdram_cmd_pkg::COL_W-1:0]  col;
        logic [sdram_cmd_pkg::BANK_W-1:0] bank;
        logic [31:0]                  wdata;
        logic [sdram_cmd_pkg::BE_W-1:0]   be;
        sdram_cmd_pkg::req_s          req;
        logic                         req_tgl;
        logic                         ack_s1;
        logic                         ack_s2;
        logic                         ack_s3;
        logic                         busy;
        logic [31:0]                  rdbuf;
        logic [31:0]                  rd_q;
    } core_s;

    typedef struct packed {
        logic                         rst_s1;
        logic                         rst_s2;
        logic                         req_s1;
        logic                         req_s2;
        logic                         req_s3;
        logic                         ack_tgl;
        sdram_cmd_pkg::link_state_e   st;
        logic [3:0]                   cnt;
        logic [sdram_cmd_pkg::NBANK-1:0] open;
        logic [sdram_cmd_pkg::NBANK-1:0][sdram_cmd_pkg::ADDR_W-1:0] rows;
        sdram_cmd_pkg::req_s          cur;
        logic [31:0]                  rdata;
        logic                         sref;
        sdram_cmd_pkg::pins_s         pins;
    } link_s;

    core_s c_r;
    core_s c_nxt;
    link_s l_r;
    link_s l_nxt;

    // ----------------------------------------
    // pin encoding helper
    // ----------------------------------------
    function automatic sdram_cmd_pkg::pins_s encode(
        input logic [3:0]          cs_ras_cas_we,
        input sdram_cmd_pkg::pins_s base
    );
        sdram_cmd_pkg::pins_s p;
        p        = base;
        p.cs_n   = cs_ras_cas_we[3];
        p.ras_n  = cs_ras_cas_we[2];
        p.cas_n  = cs_ras_cas_we[1];
        p.we_n   = cs_ras_cas_we[0];
        p.strobe = 1'b0;
        p.oe     = 1'b0;
        return p;
    endfunction

    // ----------------------------------------
    // core domain: register port
    // ----------------------------------------
    always_comb begin
        c_nxt        = c_r;
        c_nxt.ack_s1 = l_r.ack_tgl;
        c_nxt.ack_s2 = c_r.ack_s1;
        c_nxt.ack_s3 = c_r.ack_s2;
        if (c_r.ack_s2 != c_r.ack_s3) begin
            c_nxt.busy  = 1'b0;
            c_nxt.rdbuf = l_r.rdata;
        end
        if (i_wr) begin
            unique case (i_addr)
                `REG_CTRL: begin
                    c_nxt.rl = i_wdata[`CTRL_RL];
                    c_nxt.wl = i_wdata[`CTRL_WL];
                end
                `REG_ADDR: begin
                    c_nxt.row  = i_wdata[`ADDR_ROW];
                    c_nxt.col  = i_wdata[`ADDR_COL];
                    c_nxt.bank = i_wdata[`ADDR_BANK];
                end
                `REG_WDATA: c_nxt.wdata = i_wdata;
                `REG_BE:    c_nxt.be = i_wdata[`BE_FIELD];
                `REG_CMD: begin
                    // ignored while a command is in flight
                    if (!c_r.busy) begin
                        c_nxt.req.cmd   = sdram_cmd_pkg::cmd_e'(i_wdata[`CMD_CODE]);
                        c_nxt.req.src   = i_wdata[`CMD_SRC];
                        c_nxt.req.dst   = i_wdata[`CMD_DST];
                        c_nxt.req.rl    = c_r.rl;
                        c_nxt.req.wl    = c_r.wl;
                        c_nxt.req.row   = c_r.row;
                        c_nxt.req.col   = c_r.col;
                        c_nxt.req.bank  = c_r.bank;
                        c_nxt.req.wdata = c_r.wdata;
                        c_nxt.req.be    = c_r.be;
                        c_nxt.req_tgl   = ~c_r.req_tgl;
                        c_nxt.busy      = 1'b1;
                    end
                end
                default: ;
            endcase
        end
        c_nxt.rd_q = `RST_WORD;
        if (i_rd) begin
            unique case (i_addr)
                `REG_CTRL:  c_nxt.rd_q = {28'h0, c_r.wl, c_r.rl};
                `REG_ADDR:  c_nxt.rd_q = {7'h0, c_r.bank, c_r.col, c_r.row};
                `REG_WDATA: c_nxt.rd_q = c_r.wdata;
                `REG_BE:    c_nxt.rd_q = {28'h0, c_r.be};
                `REG_STAT:  c_nxt.rd_q = {31'h0, c_r.busy};
                `REG_RDATA: c_nxt.rd_q = c_r.rdbuf;
                default:    c_nxt.rd_q = `RST_WORD;
            endcase
        end
        if (!i_rstn) begin
            c_nxt         = '0;
            c_nxt.rl      = `RST_LAT;
            c_nxt.wl      = `RST_LAT;
            // toggles restart at zero in both domains
            c_nxt.ack_s1  = 1'b0;
            c_nxt.ack_s2  = 1'b0;
            c_nxt.ack_s3  = 1'b0;
            c_nxt.req_tgl = 1'b0;
        end
    end

    always_ff @(posedge i_core_clk) begin
        c_r <= c_nxt;
    end

    assign o_rdata = c_r.rd_q;

    // ----------------------------------------
    // link domain: command sequencer
    // ----------------------------------------
    logic                 req_edge;
    logic                 is_rw;
    logic                 is_rd;
    logic                 is_wr;
    logic                 direct;
    logic [3:0]           tgt;
    logic [3:0]           cnt_inc;
    sdram_cmd_pkg::req_s  rq;
    sdram_cmd_pkg::pins_s idle_p;
    sdram_cmd_pkg::pins_s main_p;
    sdram_cmd_pkg::pins_s act_p;
    sdram_cmd_pkg::pins_s pre_p;

    always_comb begin
        l_nxt        = l_r;
        l_nxt.rst_s1 = i_rstn;
        l_nxt.rst_s2 = l_r.rst_s1;
        l_nxt.req_s1 = c_r.req_tgl;
        l_nxt.req_s2 = l_r.req_s1;
        l_nxt.req_s3 = l_r.req_s2;
        req_edge     = l_r.req_s2 != l_r.req_s3;
        rq           = (l_r.st == sdram_cmd_pkg::ST_IDLE) ? c_r.req : l_r.cur;
        is_rd        = rq.cmd == sdram_cmd_pkg::CMD_READ;
        is_wr        = rq.cmd == sdram_cmd_pkg::CMD_WRITE;
        is_rw        = is_rd | is_wr;
        direct       = (is_rd & rq.src) | (is_wr & rq.dst);
        tgt          = is_rd ? `CAS_LAT + (direct ? {2'h0, rq.rl} : 4'h0)
                     : (direct ? {2'h0, rq.wl} : 4'h0);
        cnt_inc      = l_r.cnt + `CNT_ONE;
        // nop with chip select asserted keeps clock enable as is
        idle_p       = encode(4'h7, l_r.pins);
        idle_p.cke   = ~l_r.sref;
        pre_p        = encode(4'h2, idle_p);
        pre_p.bank   = rq.bank;
        pre_p.addr   = '0;
        act_p        = encode(4'h3, idle_p);
        act_p.bank   = rq.bank;
        act_p.addr   = rq.row;
        main_p       = idle_p;
        main_p.bank  = rq.bank;
        unique case (rq.cmd)
            sdram_cmd_pkg::CMD_ACTIVATE: main_p = act_p;
            sdram_cmd_pkg::CMD_READ: begin
                main_p      = encode(4'h5, main_p);
                main_p.addr = {3'h0, rq.col};
            end
            sdram_cmd_pkg::CMD_WRITE: begin
                main_p        = encode(4'h4, main_p);
                main_p.addr   = {3'h0, rq.col};
                main_p.data   = rq.wdata;
                main_p.be_n   = ~rq.be;
                main_p.oe     = ~direct;
                main_p.strobe = direct & (tgt == 4'h0);
            end
            sdram_cmd_pkg::CMD_PRE_ALL: begin
                main_p               = encode(4'h2, main_p);
                main_p.addr          = '0;
                main_p.addr[`AP_BIT] = 1'b1;
            end
            sdram_cmd_pkg::CMD_PRE_BANK: main_p = pre_p;
            sdram_cmd_pkg::CMD_REFRESH:  main_p = encode(4'h1, main_p);
            sdram_cmd_pkg::CMD_MODE_SET: begin
                main_p      = encode(4'h0, main_p);
                main_p.addr = rq.row;
            end
            sdram_cmd_pkg::CMD_SREF_IN: begin
                if (WIDE) begin
                    main_p     = encode(4'h1, main_p);
                    main_p.cke = 1'b0;
                end
            end
            sdram_cmd_pkg::CMD_SREF_OUT: main_p.cke = 1'b1;
            default: ;
        endcase
        unique case (l_r.st)
            sdram_cmd_pkg::ST_IDLE: begin
                l_nxt.pins      = idle_p;
                l_nxt.pins.cs_n = 1'b1;
                if (req_edge) begin
                    l_nxt.cur = rq;
                    l_nxt.cnt = 4'h0;
                    if (is_rw && l_r.open[rq.bank] && l_r.rows[rq.bank] != rq.row) begin
                        l_nxt.pins = pre_p;
                        l_nxt.st   = sdram_cmd_pkg::ST_PRE;
                    end else if (is_rw && !l_r.open[rq.bank]) begin
                        l_nxt.pins = act_p;
                        l_nxt.st   = sdram_cmd_pkg::ST_ACT;
                    end else begin
                        l_nxt.pins = main_p;
                        l_nxt.st   = sdram_cmd_pkg::ST_RUN;
                    end
                end
            end
            sdram_cmd_pkg::ST_PRE: begin
                l_nxt.pins = idle_p;
                l_nxt.cnt  = cnt_inc;
                if (l_r.cnt == GAP) begin
                    l_nxt.pins = act_p;
                    l_nxt.cnt  = 4'h0;
                    l_nxt.st   = sdram_cmd_pkg::ST_ACT;
                end
            end
            sdram_cmd_pkg::ST_ACT: begin
                l_nxt.pins = idle_p;
                l_nxt.cnt  = cnt_inc;
                if (l_r.cnt == GAP) begin
                    l_nxt.pins = main_p;
                    l_nxt.cnt  = 4'h0;
                    l_nxt.st   = sdram_cmd_pkg::ST_RUN;
                end
            end
            sdram_cmd_pkg::ST_RUN: begin
                l_nxt.pins        = idle_p;
                l_nxt.cnt         = cnt_inc;
                l_nxt.pins.strobe = direct & (cnt_inc == tgt);
                // third edge after the read command
                if (is_rd && !direct && cnt_inc == `CAS_LAT) begin
                    l_nxt.rdata = i_external_data_bus;
                end
                if (l_r.cnt == tgt) begin
                    l_nxt.pins.strobe = 1'b0;
                    l_nxt.ack_tgl     = ~l_r.ack_tgl;
                    l_nxt.st          = sdram_cmd_pkg::ST_IDLE;
                end
            end
            default: l_nxt.st = sdram_cmd_pkg::ST_IDLE;
        endcase
        // bookkeeping of open rows on every activate and precharge leaving the pins
        if (l_nxt.pins.cs_n == 1'b0 && l_nxt.pins.cas_n && !l_nxt.pins.ras_n) begin
            if (!l_nxt.pins.we_n) begin
                if (l_nxt.pins.addr[`AP_BIT]) begin
                    l_nxt.open = '0;
                end else begin
                    l_nxt.open[l_nxt.pins.bank] = 1'b0;
                end
            end else begin
                l_nxt.open[l_nxt.pins.bank] = 1'b1;
                l_nxt.rows[l_nxt.pins.bank] = l_nxt.pins.addr;
            end
        end
        l_nxt.sref = ~l_nxt.pins.cke;
        if (!l_r.rst_s2) begin
            l_nxt             = '0;
            l_nxt.rst_s1      = i_rstn;
            l_nxt.rst_s2      = l_r.rst_s1;
            l_nxt.req_s1      = c_r.req_tgl;
            l_nxt.req_s2      = l_r.req_s1;
            l_nxt.req_s3      = l_r.req_s2;
            l_nxt.ack_tgl     = 1'b0;
            l_nxt.st          = sdram_cmd_pkg::ST_IDLE;
            l_nxt.pins.cs_n   = 1'b1;
            l_nxt.pins.ras_n  = 1'b1;
            l_nxt.pins.cas_n  = 1'b1;
            l_nxt.pins.we_n   = 1'b1;
            l_nxt.pins.cke    = 1'b1;
            l_nxt.pins.be_n   = '1;
        end
    end

    always_ff @(posedge i_mem_clk) begin
        l_r <= l_nxt;
    end

    // ----------------------------------------
    // pins
    // ----------------------------------------
    assign o_memory_clock_out        = i_mem_clk;
    assign o_chip_select_n           = l_r.pins.cs_n;
    assign o_row_strobe_n            = l_r.pins.ras_n;
    assign o_column_strobe_n         = l_r.pins.cas_n;
    assign o_mem_write_strobe_n      = l_r.pins.we_n;
    assign o_sdram_clock_enable_wide = WIDE & l_r.pins.cke;
    assign o_direct_transfer_strobe  = l_r.pins.strobe;
    assign o_external_address_bus    = l_r.pins.addr;
    assign o_bank                    = l_r.pins.bank;
    assign o_byte_enable_n           = l_r.pins.be_n;
    assign o_external_data_bus       = l_r.pins.data;
    assign o_external_data_bus_oe    = l_r.pins.oe;

endmodule

`default_nettype wire

// ===== bench/sdram_command_port_props.sv
`timescale 1ns/1ps
`default_nettype none

module sdram_command_port_props #(
    parameter bit WIDE = 1'b1
) (
    input wire logic        i_rstn,
    input wire logic        i_mem_clk,
    input wire logic        o_chip_select_n,
    input wire logic        o_row_strobe_n,
    input wire logic        o_column_strobe_n,
    input wire logic        o_mem_write_strobe_n,
    input wire logic        o_sdram_clock_enable_wide,
    input wire logic        o_direct_transfer_strobe,
    input wire logic [12:0] o_external_address_bus,
    input wire logic [1:0]  o_bank,
    input wire logic        o_external_data_bus_oe
);
    // ----------------------------------------
    // command decode and open-row tracking
    // ----------------------------------------
    logic [3:0] nib;
    logic       rw_c;
    logic [3:0] open_r;
    logic [3:0] since_r;
    assign nib  = {o_chip_select_n, o_row_strobe_n, o_column_strobe_n, o_mem_write_strobe_n};
    assign rw_c = nib[3:1] == 3'h2;

    always_ff @(posedge i_mem_clk) begin
        if (!i_rstn) begin
            open_r  <= 4'h0;
            since_r <= 4'hf;
        end else begin
            if (nib == 4'h3) open_r[o_bank] <= 1'b1;
            if (nib == 4'h2 && o_external_address_bus[10]) open_r <= 4'h0;
            else if (nib == 4'h2) open_r[o_bank] <= 1'b0;
            if (rw_c) since_r <= 4'h0;
            else if (since_r != 4'hf) since_r <= since_r + 4'h1;
        end
    end

    default clocking cb @(posedge i_mem_clk); endclocking
    default disable iff (!i_rstn);

    sequence s_quiet3;
        (nib[2:0] == 3'h7) [*3];
    endsequence
    sequence s_write_then_off;
        (nib == 4'h4) ##1 !o_external_data_bus_oe;
    endsequence

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    a_oe_write_only: assert property (o_external_data_bus_oe |-> s_write_then_off)
        else $error("bus driven outside write");
    a_cmd_one_cycle: assert property (!nib[3] && nib[2:0] != 3'h7 |=> nib[2:0] == 3'h7)
        else $error("command over one cycle");
    a_read_quiet: assert property (nib == 4'h5 |=> s_quiet3)
        else $error("command in read latency");
    a_strobe_pulse: assert property ($rose(o_direct_transfer_strobe) |=> !o_direct_transfer_strobe)
        else $error("strobe over one cycle");
    a_strobe_window: assert property (o_direct_transfer_strobe |-> rw_c || since_r <= 4'h5)
        else $error("strobe outside window");
    a_pre_addr_bit: assert property (nib == 4'h2 |-> o_external_address_bus[10] || o_external_address_bus == 13'h0)
        else $error("bad precharge address");
    a_row_open: assert property (rw_c |-> open_r[o_bank])
        else $error("access to closed bank");
    a_cke_narrow: assert property (!WIDE |-> !o_sdram_clock_enable_wide)
        else $error("clock enable on narrow");
    a_sref_entry: assert property ($fell(o_sdram_clock_enable_wide) |-> nib == 4'h1)
        else $error("clock enable fell without refresh");
endmodule

bind sdram_command_port sdram_command_port_props #(.WIDE(WIDE)) u_props (
    .i_rstn(i_rstn), .i_mem_clk(i_mem_clk), .o_chip_select_n(o_chip_select_n),
    .o_row_strobe_n(o_row_strobe_n), .o_column_strobe_n(o_column_strobe_n),
    .o_mem_write_strobe_n(o_mem_write_strobe_n),
    .o_sdram_clock_enable_wide(o_sdram_clock_enable_wide),
    .o_direct_transfer_strobe(o_direct_transfer_strobe),
    .o_external_address_bus(o_external_address_bus), .o_bank(o_bank),
    .o_external_data_bus_oe(o_external_data_bus_oe));

`default_nettype wire

// ===== bench/sdram_model.sv
`timescale 1ns/1ps
`default_nettype none

module sdram_model (
    input  wire logic        i_clk,
    input  wire logic [3:0]  i_cmd,
    input  wire logic [1:0]  i_bank,
    input  wire logic [12:0] i_addr,
    input  wire logic [3:0]  i_be_n,
    input  wire logic [31:0] i_dq,
    input  wire logic        i_oe,
    output logic      [31:0] o_dq
);
    logic [31:0] mem [256];
    logic        rd_seen;
    logic [7:0]  rd_idx;

    initial begin
        for (int i = 0; i < 256; i++) mem[i] = 32'h5a00_0000 | i;
        o_dq    = 32'h0;
        rd_seen = 1'b0;
    end

    // read data stands one cycle, else inverted
    always @(posedge i_clk) begin
        rd_seen <= (i_cmd == 4'h5);
        rd_idx  <= {i_bank, i_addr[5:0]};
        o_dq    <= rd_seen ? mem[rd_idx] : ~o_dq;
        if (i_cmd == 4'h4 && i_oe) begin
            for (int b = 0; b < 4; b++) begin
                if (!i_be_n[b]) mem[{i_bank, i_addr[5:0]}][8*b +: 8] <= i_dq[8*b +: 8];
            end
        end
    end
endmodule

`default_nettype wire

// ===== bench/tb_sdram_command_port.sv
`timescale 1ns/1ps
`default_nettype none
`include "sdram_cmd_regs.svh"
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin fail_count++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, (got), (exp)); end end

module tb_sdram_command_port;
    typedef struct packed {
        logic [5:0]  cmd;
        logic [24:0] addr;
        logic [3:0]  nib;
        logic [14:0] mask;
        logic [14:0] exp;
    } row_s;
    localparam logic [31:0] WD = 32'hc3d2_0e17;

    logic        i_core_clk = 1'b0;
    logic        i_mem_clk  = 1'b0;
    logic        i_rstn     = 1'b0;
    logic        i_wr       = 1'b0;
    logic        i_rd       = 1'b0;
    logic [7:0]  i_addr     = 8'h00;
    logic [31:0] i_wdata    = 32'h0;
    logic [31:0] o_rdata, dq_out, dq_in, last_data, rd_v, saved;
    logic        mclk, cs_n, ras_n, cas_n, we_n, cke, strobe, oe;
    logic [12:0] ea;
    logic [1:0]  bank;
    logic [3:0]  be_n, last_nib, last_be;
    logic [14:0] last_ab;
    int fail_count = 0, total_checks = 0, cmd_count = 0, strobe_count = 0, oe_count = 0;
    int lcyc = 0, rw_cyc = 0, strobe_cyc = 0, ccyc = 0, n0;
    row_s rows [7] = '{
        '{6'h04, 25'h0, 4'h2, 15'h0400, 15'h0400},
        '{6'h07, 25'h32, 4'h0, 15'h1fff, 15'h0032},
        '{6'h06, 25'h0, 4'h1, 15'h0, 15'h0},
        '{6'h01, 25'h0800005, 4'h3, 15'h7fff, 15'h2005},
        '{6'h03, 25'h0824005, 4'h4, 15'h7fff, 15'h2012},
        '{6'h02, 25'h0824005, 4'h5, 15'h7fff, 15'h2012},
        '{6'h05, 25'h0800000, 4'h2, 15'h7fff, 15'h2000}};

    sdram_command_port dut (
        .i_core_clk(i_core_clk), .i_rstn(i_rstn), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_mem_clk(i_mem_clk),
        .o_memory_clock_out(mclk), .o_chip_select_n(cs_n), .o_row_strobe_n(ras_n),
        .o_column_strobe_n(cas_n), .o_mem_write_strobe_n(we_n),
        .o_sdram_clock_enable_wide(cke), .o_direct_transfer_strobe(strobe),
        .o_external_address_bus(ea), .o_bank(bank), .o_byte_enable_n(be_n),
        .o_external_data_bus(dq_out), .o_external_data_bus_oe(oe), .i_external_data_bus(dq_in));
    sdram_model mem_model (
        .i_clk(mclk), .i_cmd({cs_n, ras_n, cas_n, we_n}), .i_bank(bank), .i_addr(ea),
        .i_be_n(be_n), .i_dq(dq_out), .i_oe(oe), .o_dq(dq_in));

    initial forever #25 i_core_clk = ~i_core_clk;
    initial #7 forever #16 i_mem_clk = ~i_mem_clk;

    // ----------------------------------------
    // pin monitor and timeout
    // ----------------------------------------
    always @(posedge i_mem_clk) begin
        lcyc++;
        if (!cs_n && {ras_n, cas_n, we_n} != 3'h7) begin
            cmd_count++;
            last_nib = {cs_n, ras_n, cas_n, we_n};
            last_ab  = {bank, ea};
            if (ras_n && !cas_n) rw_cyc = lcyc;
        end
        if (strobe) begin
            strobe_count++;
            strobe_cyc = lcyc;
        end
        if (oe) begin
            oe_count++;
            last_be   = be_n;
            last_data = dq_out;
        end
    end
    always @(posedge i_core_clk) begin
        ccyc++;
        if (ccyc == 20000) begin
            fail_count++;
            tally_and_finish();
        end
    end

    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_core_clk);
        i_wr    <= 1'b1;
        i_addr  <= a;
        i_wdata <= d;
        @(posedge i_core_clk);
        i_wr <= 1'b0;
    endtask
    task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge i_core_clk);
        i_rd   <= 1'b1;
        i_addr <= a;
        @(posedge i_core_clk);
        i_rd <= 1'b0;
        #1 d = o_rdata;
    endtask
    task automatic do_cmd(input logic [5:0] c, input logic [24:0] a);
        logic [31:0] s;
        reg_wr(`REG_ADDR, {7'h0, a});
        reg_wr(`REG_CMD, {26'h0, c});
        s = 32'h1;
        for (int n = 0; n < 200 && s[0] !== 1'b0; n++) reg_rd(`REG_STAT, s);
        if (s[0] !== 1'b0) fail_count++;
        repeat (8) @(posedge i_mem_clk);
    endtask
    task automatic tally_and_finish();
        $display("checks %0d, mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        repeat (4) @(posedge i_core_clk);
        i_rstn <= 1'b1;
        repeat (10) @(posedge i_mem_clk);
        `CHK({cs_n, oe, strobe, cke, be_n}, 8'h9f)
        `CHK(o_rdata, 32'h0)
        reg_wr(`REG_WDATA, WD);
        reg_wr(`REG_BE, 32'hf);
        for (int i = 0; i < 7; i++) begin
            n0 = cmd_count;
            do_cmd(rows[i].cmd, rows[i].addr);
            `CHK(last_nib, rows[i].nib)
            `CHK(last_ab & rows[i].mask, rows[i].exp)
            `CHK(cmd_count - n0, 1)
        end
        `CHK({last_be, last_data}, {4'h0, WD})
        reg_rd(`REG_RDATA, rd_v);
        `CHK(rd_v, WD)
        n0 = cmd_count;
        do_cmd(6'h02, 25'h1000007);
        `CHK(cmd_count - n0, 2)
        n0 = cmd_count;
        do_cmd(6'h02, 25'h1000009);
        `CHK(cmd_count - n0, 3)
        reg_rd(`REG_RDATA, saved);
        `CHK(saved, 32'h5a00_0080)
        reg_rd(8'hfc, rd_v);
        `CHK(rd_v, 32'h0)
        for (int l = 0; l < 4; l++) begin
            reg_wr(`REG_CTRL, l);
            n0 = strobe_count;
            do_cmd(6'h12, 25'h100a009);
            `CHK(strobe_cyc - rw_cyc, 3 + l)
            `CHK(strobe_count - n0, 1)
            reg_rd(`REG_RDATA, rd_v);
            `CHK(rd_v, saved)
            reg_wr(`REG_CTRL, l << 2);
            n0 = oe_count;
            do_cmd(6'h23, 25'h100a009);
            `CHK(strobe_cyc - rw_cyc, l)
            `CHK(oe_count - n0, 0)
        end
        n0 = strobe_count;
        do_cmd(6'h22, 25'h100a009);
        `CHK(strobe_count - n0, 0)
        do_cmd(6'h04, 25'h0);
        do_cmd(6'h08, 25'h0);
        `CHK(cke, 1'b0)
        do_cmd(6'h09, 25'h0);
        `CHK(cke, 1'b1)
        tally_and_finish();
    end
endmodule

`default_nettype wire
